// [logic/dual_data_pointer_pkg.sv]
// Constants shared by the dual data pointer unit and its serial number store
package dual_data_pointer_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_PTR_LOW   = 8'h82;
   localparam logic [7:0]  ADDR_PTR_HIGH  = 8'h83;
   localparam logic [7:0]  ADDR_AUX_CTRL  = 8'hA2;

   // ----------------------------------------------------------------
   // Auxiliary control field positions
   // ----------------------------------------------------------------
   localparam int          SEL_BIT        = 0;
   localparam int          ZERO_BIT       = 1;
   localparam int          FLAG_BIT       = 3;

   // ----------------------------------------------------------------
   // Reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [15:0] PTR_RESET      = 16'h0000;
   localparam logic        SEL_RESET      = 1'b0;
   localparam logic        FLAG_RESET     = 1'b0;
   localparam logic [7:0]  READ_RESET     = 8'h00;
   localparam int          POINTER_COUNT  = 2;
   localparam int          SERIAL_BYTES   = 12;
   localparam int          SERIAL_INDEX_W = 4;

endpackage : dual_data_pointer_pkg

// [logic/serial_number_if.sv]
// Carrier between the pointer unit and its serial number store
`timescale 1ns/1ps
`default_nettype none

interface serial_number_if;
   logic       readEn;
   logic [3:0] index;
   logic [7:0] data;

   modport requester (output readEn, output index, input data);
   modport store     (input readEn, input index, output data);
endinterface : serial_number_if

`default_nettype wire

// [logic/serial_number_store.sv]
// Factory serial number store, byte readable through the programming command path
`timescale 1ns/1ps
`default_nettype none

module serial_number_store #(
   parameter int                               SERIAL_BYTES = dual_data_pointer_pkg::SERIAL_BYTES,
   // Arbitrary neutral value
   parameter logic [SERIAL_BYTES*8-1:0]        SERIAL_VALUE = {SERIAL_BYTES{8'h5A}}
) (
   input  wire logic    clk,
   input  wire logic    reset_n,
   input  wire logic    ce,
   serial_number_if.store port
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (SERIAL_BYTES < 1 || SERIAL_BYTES > 16) begin : g_bad_size
      $error("serial_number_store: SERIAL_BYTES must be 1 to 16");
   end

   typedef struct packed {
      logic [7:0] data;
   } store_t;

   store_t state_reg;
   store_t state_next;

   // ----------------------------------------------------------------
   // Registered byte read
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (ce && port.readEn) begin
         state_next.data = 8'h00;
         for (int i = 0; i < SERIAL_BYTES; i++) begin
            if (port.index == i[3:0]) begin
               state_next.data = SERIAL_VALUE[i*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg.data <= dual_data_pointer_pkg::READ_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign port.data = state_reg.data;

   property p_serial_byte;
      @(posedge clk) disable iff (!reset_n)
      (ce && port.readEn && port.index == 4'h0) |=> (port.data == SERIAL_VALUE[7:0]);
   endproperty
   a_serial_byte: assert property (p_serial_byte) else $error("serial byte zero wrong");

endmodule : serial_number_store

`default_nettype wire

// [logic/dual_data_pointer_unit.sv]
// Dual data pointer unit with auxiliary control register and serial number access
`timescale 1ns/1ps
`default_nettype none


module dual_data_pointer_unit #(
   parameter int SERIAL_BYTES = dual_data_pointer_pkg::SERIAL_BYTES
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   input  wire logic [7:0]  sfrAddr,
   input  wire logic        sfrWrEn,
   input  wire logic [7:0]  sfrWrData,
   input  wire logic        sfrRdEn,
   output var  logic [7:0]  sfrRdData,
   input  wire logic        auxIncrement,
   input  wire logic        ptrIncrement,
   input  wire logic        ptrLoad,
   input  wire logic [15:0] ptrLoadValue,
   output var  logic [15:0] activeAddress,
   input  wire logic        progSerialRead,
   input  wire logic [3:0]  progSerialIndex,
   output var  logic [7:0]  progSerialData
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (SERIAL_BYTES < 1 || SERIAL_BYTES > 16) begin : g_bad_size
      $error("dual_data_pointer_unit: SERIAL_BYTES must be 1 to 16");
   end

   localparam int PTRS = dual_data_pointer_pkg::POINTER_COUNT;

   typedef struct packed {
      logic [PTRS-1:0][15:0] ptr;
      logic                  sel;
      logic                  flag;
      logic [7:0]            rdData;
      logic [15:0]           active;
   } state_t;

   state_t            state_reg;
   state_t            state_next;
   logic [15:0]       ptrNext [PTRS];
   logic [15:0]       curPtr;
   logic              lowWrite;
   logic              highWrite;
   logic              auxWrite;
   logic [7:0]        auxValue;
   logic [7:0]        readValue;

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   assign lowWrite  = sfrWrEn && (sfrAddr == dual_data_pointer_pkg::ADDR_PTR_LOW);
   assign highWrite = sfrWrEn && (sfrAddr == dual_data_pointer_pkg::ADDR_PTR_HIGH);
   assign auxWrite  = sfrWrEn && (sfrAddr == dual_data_pointer_pkg::ADDR_AUX_CTRL);
   assign curPtr    = state_reg.ptr[state_reg.sel];

   always_comb begin
      auxValue = 8'h00;
      auxValue[dual_data_pointer_pkg::FLAG_BIT] = state_reg.flag;
      auxValue[dual_data_pointer_pkg::SEL_BIT]  = state_reg.sel;
      auxValue[dual_data_pointer_pkg::ZERO_BIT] = 1'b0;
   end

   always_comb begin
      case (sfrAddr)
         dual_data_pointer_pkg::ADDR_PTR_LOW: begin
            readValue = curPtr[7:0];
         end
         dual_data_pointer_pkg::ADDR_PTR_HIGH: begin
            readValue = curPtr[15:8];
         end
         dual_data_pointer_pkg::ADDR_AUX_CTRL: begin
            readValue = auxValue;
         end
         default: begin
            readValue = 8'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Per-pointer update
   // ----------------------------------------------------------------
   for (genvar i = 0; i < PTRS; i++) begin : g_ptr
      logic isActive;
      assign isActive = (state_reg.sel == 1'(i));
      always_comb begin
         ptrNext[i] = state_reg.ptr[i];
         if (isActive) begin
            if (lowWrite) begin
               ptrNext[i][7:0] = sfrWrData;
            end
            if (highWrite) begin
               ptrNext[i][15:8] = sfrWrData;
            end
            if (ptrLoad) begin
               ptrNext[i] = ptrLoadValue;
            end else if (ptrIncrement) begin
               ptrNext[i] = 16'(state_reg.ptr[i] + 16'h0001);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (ce) begin
         for (int i = 0; i < PTRS; i++) begin
            state_next.ptr[i] = ptrNext[i];
         end
         if (auxWrite) begin
            state_next.sel  = sfrWrData[dual_data_pointer_pkg::SEL_BIT];
            state_next.flag = sfrWrData[dual_data_pointer_pkg::FLAG_BIT];
         end
         if (auxIncrement) begin
            state_next.sel  = ~state_reg.sel;
            state_next.flag = state_reg.flag;
         end
         if (sfrRdEn) begin
            state_next.rdData = readValue;
         end
         state_next.active = state_next.ptr[state_next.sel];
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg.ptr    <= {PTRS{dual_data_pointer_pkg::PTR_RESET}};
         state_reg.sel    <= dual_data_pointer_pkg::SEL_RESET;
         state_reg.flag   <= dual_data_pointer_pkg::FLAG_RESET;
         state_reg.rdData <= dual_data_pointer_pkg::READ_RESET;
         state_reg.active <= dual_data_pointer_pkg::PTR_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sfrRdData     = state_reg.rdData;
   assign activeAddress = state_reg.active;

   // ----------------------------------------------------------------
   // Serial number store
   // ----------------------------------------------------------------
   serial_number_if serialBus ();

   assign serialBus.readEn = progSerialRead;
   assign serialBus.index  = progSerialIndex;
   assign progSerialData   = serialBus.data;

   serial_number_store #(
      .SERIAL_BYTES (SERIAL_BYTES)
   ) u_serial (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .port    (serialBus.store)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_inactive_hold;
      @(posedge clk) disable iff (!reset_n)
      (state_reg.ptr[1] != $past(state_reg.ptr[1])) |-> ($past(state_reg.sel) == 1'b1);
   endproperty
   a_inactive_hold: assert property (p_inactive_hold) else $error("inactive pointer changed");

   property p_first_hold;
      @(posedge clk) disable iff (!reset_n)
      state_reg.sel |=> $stable(state_reg.ptr[0]);
   endproperty
   a_first_hold: assert property (p_first_hold) else $error("first pointer changed while deselected");

   property p_zero_bit;
      @(posedge clk) disable iff (!reset_n)
      (ce && sfrRdEn && sfrAddr == dual_data_pointer_pkg::ADDR_AUX_CTRL)
         |=> (sfrRdData[1] == 1'b0 && sfrRdData[0] == $past(state_reg.sel));
   endproperty
   a_zero_bit: assert property (p_zero_bit) else $error("auxiliary control read wrong");

   property p_select_write;
      @(posedge clk) disable iff (!reset_n)
      (ce && auxWrite && !auxIncrement)
         |=> (state_reg.sel == $past(sfrWrData[0]) && state_reg.flag == $past(sfrWrData[3]));
   endproperty
   a_select_write: assert property (p_select_write) else $error("select or flag not written");

   property p_aux_increment;
      @(posedge clk) disable iff (!reset_n)
      (ce && auxIncrement) |=> (state_reg.sel != $past(state_reg.sel)) && $stable(state_reg.flag);
   endproperty
   a_aux_increment: assert property (p_aux_increment) else $error("increment did not toggle select");

   property p_active_address;
      @(posedge clk) disable iff (!reset_n)
      activeAddress == state_reg.ptr[state_reg.sel];
   endproperty
   a_active_address: assert property (p_active_address) else $error("address not from active pointer");

   property p_low_write;
      @(posedge clk) disable iff (!reset_n)
      (ce && lowWrite && !ptrLoad && !ptrIncrement && !auxIncrement && !auxWrite)
         ##1 (ce && sfrRdEn && sfrAddr == dual_data_pointer_pkg::ADDR_PTR_LOW)
         |=> (sfrRdData == $past(sfrWrData, 2));
   endproperty
   a_low_write: assert property (p_low_write) else $error("low byte readback wrong");

   property p_unmapped_read;
      @(posedge clk) disable iff (!reset_n)
      (ce && sfrRdEn && sfrAddr != dual_data_pointer_pkg::ADDR_PTR_LOW
         && sfrAddr != dual_data_pointer_pkg::ADDR_PTR_HIGH
         && sfrAddr != dual_data_pointer_pkg::ADDR_AUX_CTRL) |=> (sfrRdData == 8'h00);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_ptr_increment;
      @(posedge clk) disable iff (!reset_n)
      (ce && ptrIncrement && !ptrLoad && !auxIncrement && !auxWrite)
         |=> (activeAddress == 16'($past(curPtr) + 16'h0001));
   endproperty
   a_ptr_increment: assert property (p_ptr_increment) else $error("active pointer not incremented");

   property p_ptr_load;
      @(posedge clk) disable iff (!reset_n)
      (ce && ptrLoad && !auxIncrement && !auxWrite) |=> (activeAddress == $past(ptrLoadValue));
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("active pointer not loaded");

   property p_freeze;
      @(posedge clk) disable iff (!reset_n)
      !ce |=> $stable(state_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

   property p_high_write;
      @(posedge clk) disable iff (!reset_n)
      (ce && highWrite && !ptrLoad && !ptrIncrement && !auxIncrement && !auxWrite)
         ##1 (ce && sfrRdEn && sfrAddr == dual_data_pointer_pkg::ADDR_PTR_HIGH)
         |=> (sfrRdData == $past(sfrWrData, 2));
   endproperty
   a_high_write: assert property (p_high_write) else $error("high byte readback wrong");

   property p_aux_read_mask;
      @(posedge clk) disable iff (!reset_n)
      (ce && sfrRdEn && sfrAddr == dual_data_pointer_pkg::ADDR_AUX_CTRL)
         |=> (sfrRdData[7:4] == 4'h0 && sfrRdData[2] == 1'h0 && sfrRdData[3] == $past(state_reg.flag));
   endproperty
   a_aux_read_mask: assert property (p_aux_read_mask) else $error("aux control spare bits wrong");

   property p_read_hold;
      @(posedge clk) disable iff (!reset_n)
      !(ce && sfrRdEn) |=> $stable(sfrRdData);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read data moved without a read");

   property p_select_hold;
      @(posedge clk) disable iff (!reset_n)
      !(ce && (auxWrite || auxIncrement)) |=> $stable(state_reg.sel);
   endproperty
   a_select_hold: assert property (p_select_hold) else $error("select moved without a request");

   property p_flag_hold;
      @(posedge clk) disable iff (!reset_n)
      !(ce && auxWrite) |=> $stable(state_reg.flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag moved without a write");

   property p_second_hold;
      @(posedge clk) disable iff (!reset_n)
      !state_reg.sel |=> $stable(state_reg.ptr[1]);
   endproperty
   a_second_hold: assert property (p_second_hold) else $error("second pointer changed while deselected");

   property p_wrap;
      @(posedge clk) disable iff (!reset_n)
      (ce && ptrIncrement && !ptrLoad && !auxIncrement && !auxWrite && curPtr == 16'hFFFF)
         |=> (activeAddress == 16'h0000);
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer increment did not wrap");

   property p_select_op_old;
      @(posedge clk) disable iff (!reset_n)
      (ce && auxIncrement && ptrLoad)
         |=> (state_reg.ptr[$past(state_reg.sel)] == $past(ptrLoadValue));
   endproperty
   a_select_op_old: assert property (p_select_op_old) else $error("load missed the old pointer");

endmodule : dual_data_pointer_unit

`default_nettype wire

// [test/core_datapath_model.sv]
// Behavioural core datapath driving the pointer unit strobes
`timescale 1ns/1ps
`default_nettype none

module core_datapath_model (
   input  wire logic        clk,
   output var  logic [7:0]  sfrAddr,
   output var  logic        sfrWrEn,
   output var  logic [7:0]  sfrWrData,
   output var  logic        sfrRdEn,
   output var  logic        auxIncrement,
   output var  logic        ptrIncrement,
   output var  logic        ptrLoad,
   output var  logic [15:0] ptrLoadValue,
   output var  logic        progSerialRead,
   output var  logic [3:0]  progSerialIndex
);
   initial begin
      {progSerialRead, ptrLoad, ptrIncrement, auxIncrement, sfrWrEn, sfrRdEn} = 6'h00;
      sfrAddr = 8'h00;
      sfrWrData = 8'h00;
      ptrLoadValue = 16'h0000;
      progSerialIndex = 4'h0;
   end

   // ----------------------------------------------------------------
   // One request held across one rising edge
   // ----------------------------------------------------------------
   task automatic op(input logic [5:0] s, input logic [7:0] a, input logic [15:0] v);
      @(negedge clk);
      {progSerialRead, ptrLoad, ptrIncrement, auxIncrement, sfrWrEn, sfrRdEn} = s;
      sfrAddr = a;
      sfrWrData = v[7:0];
      ptrLoadValue = v;
      progSerialIndex = v[3:0];
      @(negedge clk);
      {progSerialRead, ptrLoad, ptrIncrement, auxIncrement, sfrWrEn, sfrRdEn} = 6'h00;
   endtask : op

   // ----------------------------------------------------------------
   // Register write followed at once by a read of the same address
   // ----------------------------------------------------------------
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {progSerialRead, ptrLoad, ptrIncrement, auxIncrement, sfrWrEn, sfrRdEn} = 6'h02;
      sfrAddr = a;
      sfrWrData = d;
      @(negedge clk);
      {progSerialRead, ptrLoad, ptrIncrement, auxIncrement, sfrWrEn, sfrRdEn} = 6'h01;
      @(negedge clk);
      {progSerialRead, ptrLoad, ptrIncrement, auxIncrement, sfrWrEn, sfrRdEn} = 6'h00;
   endtask : wr_rd
endmodule : core_datapath_model

`default_nettype wire

// [test/dual_data_pointer_unit_tb.sv]
// Self-checking bench for the dual data pointer unit
`timescale 1ns/1ps
`default_nettype none

module dual_data_pointer_unit_tb;
   localparam logic [5:0] RD  = 6'h01;
   localparam logic [5:0] WR  = 6'h02;
   localparam logic [5:0] AUX = 6'h04;
   localparam logic [5:0] INC = 6'h08;
   localparam logic [5:0] LD  = 6'h10;
   localparam logic [5:0] SER = 6'h20;
   localparam logic [7:0] LO  = dual_data_pointer_pkg::ADDR_PTR_LOW;
   localparam logic [7:0] HI  = dual_data_pointer_pkg::ADDR_PTR_HIGH;
   localparam logic [7:0] AC  = dual_data_pointer_pkg::ADDR_AUX_CTRL;

   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  sfrAddr, sfrWrData, sfrRdData, progSerialData;
   logic        sfrWrEn, sfrRdEn, auxIncrement, ptrIncrement, ptrLoad, progSerialRead;
   logic [15:0] ptrLoadValue, activeAddress;
   logic [3:0]  progSerialIndex;
   int          mismatches = 0;
   int          tests_run = 0;

   core_datapath_model u_core (
      .clk(clk), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
      .sfrRdEn(sfrRdEn), .auxIncrement(auxIncrement), .ptrIncrement(ptrIncrement),
      .ptrLoad(ptrLoad), .ptrLoadValue(ptrLoadValue), .progSerialRead(progSerialRead),
      .progSerialIndex(progSerialIndex));

   dual_data_pointer_unit u_dut (
      .clk(clk), .reset_n(reset_n), .ce(ce), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
      .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
      .auxIncrement(auxIncrement), .ptrIncrement(ptrIncrement), .ptrLoad(ptrLoad),
      .ptrLoadValue(ptrLoadValue), .activeAddress(activeAddress),
      .progSerialRead(progSerialRead), .progSerialIndex(progSerialIndex), .progSerialData(progSerialData));

   always #2 clk = ~clk;

   // ----------------------------------------------------------------
   // Compare and report
   // ----------------------------------------------------------------
   task automatic chk8(input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk8

   task automatic chk16(input logic [15:0] e);
      tests_run++;
      if (activeAddress !== e) begin
         mismatches++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, activeAddress);
      end
   endtask : chk16

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      u_core.op(RD, a, 16'h0000);
      chk8(e, sfrRdData);
   endtask : rd

   task automatic summarize;
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk16(16'h0000);
      rd(LO, 8'h00);
      rd(HI, 8'h00);
      rd(AC, 8'h00);
   endtask : t_reset

   task automatic t_dual;
      u_core.op(LD, 8'h00, 16'h1234);
      chk16(16'h1234);
      u_core.op(AUX, 8'h00, 16'h0000);
      chk16(16'h0000);
      rd(AC, 8'h01);
      u_core.op(LD, 8'h00, 16'hABCD);
      chk16(16'hABCD);
      u_core.op(AUX, 8'h00, 16'h0000);
      chk16(16'h1234);
      u_core.op(INC, 8'h00, 16'h0000);
      chk16(16'h1235);
      u_core.op(AUX, 8'h00, 16'h0000);
      chk16(16'hABCD);
      u_core.op(AUX, 8'h00, 16'h0000);
   endtask : t_dual

   task automatic t_bytes;
      u_core.wr_rd(LO, 8'h5A);
      chk8(8'h5A, sfrRdData);
      chk16(16'h125A);
      u_core.wr_rd(HI, 8'hC3);
      chk8(8'hC3, sfrRdData);
      chk16(16'hC35A);
      u_core.op(AUX, 8'h00, 16'h0000);
      rd(LO, 8'hCD);
      u_core.op(AUX, 8'h00, 16'h0000);
      u_core.op(LD, 8'h00, 16'hFFFF);
      u_core.op(INC, 8'h00, 16'h0000);
      chk16(16'h0000);
   endtask : t_bytes

   task automatic t_aux;
      u_core.op(WR, AC, 16'h00FF);
      rd(AC, 8'h09);
      chk16(16'hABCD);
      u_core.op(AUX, 8'h00, 16'h0000);
      rd(AC, 8'h08);
      chk16(16'h0000);
      u_core.op(WR, AC, 16'h0000);
      rd(AC, 8'h00);
   endtask : t_aux

   task automatic t_uid;
      u_core.op(SER, 8'h00, 16'h0000);
      chk8(8'h5A, progSerialData);
      u_core.op(SER, 8'h00, 16'h000B);
      chk8(8'h5A, progSerialData);
      u_core.op(SER, 8'h00, 16'h000C);
      chk8(8'h00, progSerialData);
      rd(8'h84, 8'h00);
   endtask : t_uid

   task automatic t_freeze;
      u_core.op(LD, 8'h00, 16'h4321);
      rd(LO, 8'h21);
      ce = 1'b0;
      u_core.op(INC, 8'h00, 16'h0000);
      u_core.op(AUX, 8'h00, 16'h0000);
      chk16(16'h4321);
      rd(HI, 8'h21);
      ce = 1'b1;
      rd(HI, 8'h43);
      rd(AC, 8'h00);
   endtask : t_freeze

   task automatic t_rereset;
      u_core.op(AUX | LD, 8'h00, 16'h5555);
      chk16(16'hABCD);
      u_core.op(AUX, 8'h00, 16'h0000);
      chk16(16'h5555);
      u_core.op(WR, AC, 16'h0009);
      rd(AC, 8'h09);
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      chk16(16'h0000);
      rd(AC, 8'h00);
      rd(LO, 8'h00);
      u_core.op(AUX, 8'h00, 16'h0000);
      chk16(16'h0000);
      u_core.op(AUX, 8'h00, 16'h0000);
   endtask : t_rereset

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      t_reset();
      t_dual();
      t_bytes();
      t_aux();
      t_uid();
      t_freeze();
      t_rereset();
      summarize();
   end

   initial begin
      #40000;
      mismatches++;
      summarize();
   end
endmodule : dual_data_pointer_unit_tb

`default_nettype wire
